// ==== logic/pcp_pkg.sv ====
package pcp_pkg;

  // Holding register word addresses
  localparam logic [15:0] ADDR_STATUS = 16'h000d;
  localparam logic [15:0] ADDR_COMMAND = 16'h000e;
  localparam logic [15:0] ADDR_SET_POINT = 16'h000f;
  localparam logic [15:0] ADDR_OUT_SCALE = 16'h0010;
  localparam logic [15:0] ADDR_I_CEILING = 16'h0011;
  localparam logic [15:0] ADDR_FIRING = 16'h0012;
  localparam logic [15:0] ADDR_FEEDBACK = 16'h0013;
  localparam logic [15:0] ADDR_MIN_BURST = 16'h0014;
  localparam logic [15:0] ADDR_HALF_DELAY = 16'h0015;

  // Status word bit positions
  localparam int ST_SCR_SHORT = 0;
  localparam int ST_HEATER_BREAK = 1;
  localparam int ST_OUT_ENABLE = 2;
  localparam int ST_ILIMIT = 4;
  localparam int ST_THERMAL = 5;
  localparam int ST_COMM = 6;
  localparam int ST_FUSE = 7;
  localparam int ST_DIG_IN1 = 8;
  localparam int ST_DIG_IN2 = 9;
  localparam int ST_UNBALANCE = 10;
  localparam int ST_FAN = 12;
  localparam int ST_PHASE_LOSS = 13;
  localparam int ST_BAKEOUT = 14;
  localparam int ST_THERM_LATCH = 15;

  // Command word bit positions
  localparam int CMD_SP_LOCAL = 2;
  localparam int CMD_OUT_ENABLE = 3;
  localparam int CMD_IL_LOCAL = 4;
  localparam logic [15:0] CMD_MASK = 16'h001c;

  // Function and error codes
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE_ONE = 8'h06;
  localparam logic [7:0] FN_WRITE_MANY = 8'h10;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_FUNCTION = 8'h01;
  localparam logic [7:0] ERR_ADDRESS = 8'h02;
  localparam logic [7:0] ERR_VALUE = 8'h03;
  localparam logic [7:0] ERR_QUANTITY = 8'h04;
  localparam logic [15:0] MAX_READ_QTY = 16'h0079;
  localparam logic [15:0] MAX_WRITE_QTY = 16'h0019;

  // Value limits
  localparam logic [15:0] MAX_PERMILLE = 16'h03ff;
  localparam logic [15:0] MAX_BYTE = 16'h00ff;

  // Firing and feedback codes
  localparam logic [15:0] FIRE_BURST = 16'h0003;
  localparam logic [15:0] FIRE_PHASE = 16'h0004;
  localparam logic [15:0] FIRE_HALF = 16'h000a;
  localparam logic [15:0] FIRE_VAR19 = 16'h0013;
  localparam logic [15:0] FIRE_VAR20 = 16'h0014;
  localparam logic [15:0] FIRE_VAR35 = 16'h0023;
  localparam logic [15:0] FIRE_VAR74 = 16'h004a;
  localparam logic [15:0] FB_VOLTAGE = 16'h0000;
  localparam logic [15:0] FB_NONE = 16'h0001;
  localparam logic [15:0] FB_CURRENT = 16'h0002;
  localparam logic [15:0] FB_VAR32 = 16'h0020;
  localparam logic [15:0] FB_VAR64 = 16'h0040;
  localparam logic [15:0] FB_VAR128 = 16'h0080;
  localparam logic [15:0] FB_VAR256 = 16'h0100;

  // Reset values
  localparam logic [2:0] RST_COMMAND = 3'h0;
  localparam logic [9:0] RST_SET_POINT = 10'h000;
  localparam logic [7:0] RST_OUT_SCALE = 8'hff;
  localparam logic [9:0] RST_I_CEILING = 10'h3ff;
  localparam logic [7:0] RST_MIN_BURST = 8'h01;
  localparam logic [7:0] RST_HALF_DELAY = 8'h00;

  typedef enum logic [2:0] {
    FIRE_M_BURST, FIRE_M_PHASE, FIRE_M_HALF, FIRE_M_19, FIRE_M_20, FIRE_M_35, FIRE_M_74
  } pcp_fire_type;

  typedef enum logic [2:0] {
    FB_M_VOLTAGE, FB_M_NONE, FB_M_CURRENT, FB_M_32, FB_M_64, FB_M_128, FB_M_256
  } pcp_fb_type;

endpackage : pcp_pkg

// ==== logic/pcp_regs.sv ====
// How it works
// - Status bit 0 shows thyristor short, bit 1 heater break, live.
// - Status bit 2 reads one while the power output is enabled.
// - Status bits 4 to 7 show current limit, thermal, link, fuse alarms.
// - Status bits 8 and 9 mirror digital inputs one and two.
// - Status bits 10, 12, 13 show unbalance, fan and phase loss alarms.
// - Status bit 14 reads one while a heater bakeout runs.
// - Status bit 15 holds a latched thermal alarm, apart from the live one.
// - Command bit 2 picks local set point, bit 4 local current limit.
// - A command bit enables the power output when one, disables when zero.
// - Set point and current limit hold 0 to 1023, percent is value/10.23.
// - Output scale holds 0 to 255, percent is value/2.55.
// - Firing register decodes codes 3, 4, 10, 19, 20, 35 and 74.
// - Feedback register decodes 0, 1, 2, 32, 64, 128 and 256.
// - Registers are read by function 03; all but status are written by functions 06 and 16.
module pcp_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Word requests from the frame decoder
  input wire logic req_valid,
  input wire logic req_bcast,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_qty,
  input wire logic [15:0] req_wdata,
  // Answers to the frame decoder
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [7:0] rsp_err,
  // Alarm and input pins
  input wire logic scr_short,
  input wire logic heater_break,
  input wire logic ilimit_alarm,
  input wire logic thermal_alarm,
  input wire logic comm_alarm,
  input wire logic fuse_alarm,
  input wire logic dig_in1,
  input wire logic dig_in2,
  input wire logic unbalance_alarm,
  input wire logic fan_alarm,
  input wire logic phase_loss_alarm,
  input wire logic bakeout_active,
  // Latched thermal alarm clear, same clock domain
  input wire logic therm_latch_clr,
  // Settings to the power stage
  output logic sp_local,
  output logic il_local,
  output logic out_enable,
  output logic [9:0] set_point,
  output logic [7:0] out_scale,
  output logic [9:0] current_limit,
  output pcp_pkg::pcp_fire_type fire_mode,
  output pcp_pkg::pcp_fb_type fb_mode,
  output logic [7:0] min_burst,
  output logic [7:0] half_delay
);
  import pcp_pkg::*;

  localparam int NPIN = 12;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] pin_q;
  logic therm_latch_q;
  logic therm_latch_d;
  logic [2:0] cmd_q;
  pcp_fire_type fire_q;
  pcp_fb_type fb_q;
  logic rsp_valid_q;
  logic [15:0] rsp_data_q;
  logic [7:0] rsp_err_q;

  function automatic logic fire_ok(input logic [15:0] c);
    fire_ok = (c == FIRE_BURST) || (c == FIRE_PHASE) || (c == FIRE_HALF) ||
              (c == FIRE_VAR19) || (c == FIRE_VAR20) || (c == FIRE_VAR35) ||
              (c == FIRE_VAR74);
  endfunction : fire_ok

  function automatic pcp_fire_type fire_dec(input logic [15:0] c);
    case (c)
      FIRE_PHASE: fire_dec = FIRE_M_PHASE;
      FIRE_HALF: fire_dec = FIRE_M_HALF;
      FIRE_VAR19: fire_dec = FIRE_M_19;
      FIRE_VAR20: fire_dec = FIRE_M_20;
      FIRE_VAR35: fire_dec = FIRE_M_35;
      FIRE_VAR74: fire_dec = FIRE_M_74;
      default: fire_dec = FIRE_M_BURST;
    endcase
  endfunction : fire_dec

  function automatic logic [15:0] fire_enc(input pcp_fire_type m);
    case (m)
      FIRE_M_PHASE: fire_enc = FIRE_PHASE;
      FIRE_M_HALF: fire_enc = FIRE_HALF;
      FIRE_M_19: fire_enc = FIRE_VAR19;
      FIRE_M_20: fire_enc = FIRE_VAR20;
      FIRE_M_35: fire_enc = FIRE_VAR35;
      FIRE_M_74: fire_enc = FIRE_VAR74;
      default: fire_enc = FIRE_BURST;
    endcase
  endfunction : fire_enc

  function automatic logic fb_ok(input logic [15:0] c);
    fb_ok = (c == FB_VOLTAGE) || (c == FB_NONE) || (c == FB_CURRENT) ||
            (c == FB_VAR32) || (c == FB_VAR64) || (c == FB_VAR128) || (c == FB_VAR256);
  endfunction : fb_ok

  function automatic pcp_fb_type fb_dec(input logic [15:0] c);
    case (c)
      FB_NONE: fb_dec = FB_M_NONE;
      FB_CURRENT: fb_dec = FB_M_CURRENT;
      FB_VAR32: fb_dec = FB_M_32;
      FB_VAR64: fb_dec = FB_M_64;
      FB_VAR128: fb_dec = FB_M_128;
      FB_VAR256: fb_dec = FB_M_256;
      default: fb_dec = FB_M_VOLTAGE;
    endcase
  endfunction : fb_dec

  function automatic logic [15:0] fb_enc(input pcp_fb_type m);
    case (m)
      FB_M_NONE: fb_enc = FB_NONE;
      FB_M_CURRENT: fb_enc = FB_CURRENT;
      FB_M_32: fb_enc = FB_VAR32;
      FB_M_64: fb_enc = FB_VAR64;
      FB_M_128: fb_enc = FB_VAR128;
      FB_M_256: fb_enc = FB_VAR256;
      default: fb_enc = FB_VOLTAGE;
    endcase
  endfunction : fb_enc

  // Pin synchronisers
  assign pin_raw = {bakeout_active, phase_loss_alarm, fan_alarm, unbalance_alarm,
                    dig_in2, dig_in1, fuse_alarm, comm_alarm, thermal_alarm,
                    ilimit_alarm, heater_break, scr_short};

  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        meta_q[i] <= 1'b0;
        pin_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= pin_raw[i];
        pin_q[i] <= meta_q[i];
      end
    end
  end

  // Latched thermal alarm: a new alarm wins over a clear in the same cycle
  assign therm_latch_d = pin_q[3] | (therm_latch_q & ~therm_latch_clr);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      therm_latch_q <= 1'b0;
    end else begin
      therm_latch_q <= therm_latch_d;
    end
  end

  // Status word
  wire [15:0] status_w;
  assign status_w[ST_SCR_SHORT] = pin_q[0];
  assign status_w[ST_HEATER_BREAK] = pin_q[1];
  assign status_w[ST_OUT_ENABLE] = cmd_q[1];
  assign status_w[3] = 1'b0;
  assign status_w[ST_FUSE:ST_ILIMIT] = pin_q[5:2];
  assign status_w[ST_DIG_IN2:ST_DIG_IN1] = pin_q[7:6];
  assign status_w[ST_UNBALANCE] = pin_q[8];
  assign status_w[11] = 1'b0;
  assign status_w[ST_PHASE_LOSS:ST_FAN] = pin_q[10:9];
  assign status_w[ST_BAKEOUT] = pin_q[11];
  assign status_w[ST_THERM_LATCH] = therm_latch_q;

  // Request decode
  wire is_read = (req_func == FN_READ);
  wire is_wr_one = (req_func == FN_WRITE_ONE);
  wire is_wr_many = (req_func == FN_WRITE_MANY);
  wire is_write = is_wr_one | is_wr_many;
  wire fn_bad = ~(is_read | is_write);
  wire qty_bad = (is_read && (req_qty == 16'h0000 || req_qty > MAX_READ_QTY)) ||
                 (is_wr_many && (req_qty == 16'h0000 || req_qty > MAX_WRITE_QTY));
  wire addr_bad = (req_addr < ADDR_STATUS) || (req_addr > ADDR_HALF_DELAY) ||
                  (is_write && req_addr == ADDR_STATUS);
  wire hit_cmd = (req_addr == ADDR_COMMAND);
  wire hit_sp = (req_addr == ADDR_SET_POINT);
  wire hit_os = (req_addr == ADDR_OUT_SCALE);
  wire hit_il = (req_addr == ADDR_I_CEILING);
  wire hit_fire = (req_addr == ADDR_FIRING);
  wire hit_fb = (req_addr == ADDR_FEEDBACK);
  wire hit_mb = (req_addr == ADDR_MIN_BURST);
  wire hit_hd = (req_addr == ADDR_HALF_DELAY);
  wire val_bad = ((hit_sp || hit_il) && req_wdata > MAX_PERMILLE) ||
                 ((hit_os || hit_mb || hit_hd) && req_wdata > MAX_BYTE) ||
                 (hit_fire && !fire_ok(req_wdata)) ||
                 (hit_fb && !fb_ok(req_wdata));
  wire [7:0] err_w = fn_bad ? ERR_FUNCTION :
                     qty_bad ? ERR_QUANTITY :
                     addr_bad ? ERR_ADDRESS :
                     (is_write && val_bad) ? ERR_VALUE : ERR_NONE;
  wire wr_en = req_valid && is_write && (err_w == ERR_NONE);

  // Read selection
  wire [15:0] rd_w = hit_cmd ? {11'h000, cmd_q[2:0], 2'h0} :
                     hit_sp ? {6'h00, set_point} :
                     hit_os ? {8'h00, out_scale} :
                     hit_il ? {6'h00, current_limit} :
                     hit_fire ? fire_enc(fire_q) :
                     hit_fb ? fb_enc(fb_q) :
                     hit_mb ? {8'h00, min_burst} :
                     hit_hd ? {8'h00, half_delay} : status_w;

  // Writable registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmd_q <= RST_COMMAND;
    end else if (wr_en && hit_cmd) begin
      cmd_q <= req_wdata[CMD_IL_LOCAL:CMD_SP_LOCAL];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      set_point <= RST_SET_POINT;
      current_limit <= RST_I_CEILING;
    end else begin
      if (wr_en && hit_sp) set_point <= req_wdata[9:0];
      if (wr_en && hit_il) current_limit <= req_wdata[9:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      out_scale <= RST_OUT_SCALE;
      min_burst <= RST_MIN_BURST;
      half_delay <= RST_HALF_DELAY;
    end else begin
      if (wr_en && hit_os) out_scale <= req_wdata[7:0];
      if (wr_en && hit_mb) min_burst <= req_wdata[7:0];
      if (wr_en && hit_hd) half_delay <= req_wdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fire_q <= FIRE_M_BURST;
      fb_q <= FB_M_VOLTAGE;
    end else begin
      if (wr_en && hit_fire) fire_q <= fire_dec(req_wdata);
      if (wr_en && hit_fb) fb_q <= fb_dec(req_wdata);
    end
  end

  // Answers; broadcasts act but are not answered
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
      rsp_err_q <= ERR_NONE;
    end else begin
      rsp_valid_q <= req_valid && !req_bcast;
      if (req_valid) begin
        rsp_err_q <= err_w;
        rsp_data_q <= (err_w != ERR_NONE) ? 16'h0000 : is_read ? rd_w : req_wdata;
      end
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign rsp_err = rsp_err_q;
  assign sp_local = cmd_q[0];
  assign out_enable = cmd_q[1];
  assign il_local = cmd_q[2];
  assign fire_mode = fire_q;
  assign fb_mode = fb_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence status_read_s;
    req_valid && !req_bcast && is_read && req_addr == ADDR_STATUS && req_qty == 16'h0001;
  endsequence

  scr_short_flag_a: assert property (status_read_s |=> rsp_data[0] == $past(scr_short, 3))
    else $error("status bit 0 does not follow short alarm");
  break_flag_a: assert property (status_read_s |=> rsp_data[1] == $past(heater_break, 3))
    else $error("status bit 1 does not follow heater break");
  enable_flag_a: assert property (status_read_s |=> rsp_data[2] == out_enable)
    else $error("status bit 2 differs from output enable");
  fuse_flag_a: assert property (status_read_s |=> rsp_data[7] == $past(fuse_alarm, 3))
    else $error("status bit 7 does not follow fuse alarm");
  dig_in_flag_a: assert property (status_read_s |=> rsp_data[9] == $past(dig_in2, 3))
    else $error("status bit 9 does not follow input two");
  fan_flag_a: assert property (status_read_s |=> rsp_data[12] == $past(fan_alarm, 3))
    else $error("status bit 12 does not follow fan alarm");
  bakeout_flag_a: assert property (status_read_s |=>
    rsp_data[14] == $past(bakeout_active, 3))
    else $error("status bit 14 does not follow bakeout");
  therm_latch_a: assert property (thermal_alarm [*3] |=> ##1 therm_latch_q [*2])
    else $error("thermal alarm not latched");
  unused_bits_a: assert property (status_read_s |=>
    rsp_data[3] == 1'b0 && rsp_data[11] == 1'b0)
    else $error("unused status bits not zero");
  enable_write_a: assert property (wr_en && hit_cmd |=>
    out_enable == $past(req_wdata[3]) && sp_local == $past(req_wdata[2]))
    else $error("command write not applied");
  set_point_range_a: assert property (req_valid && is_wr_one && hit_sp &&
    req_wdata > 16'h03ff |=> $stable(set_point) && rsp_err == ERR_VALUE)
    else $error("out of range set point taken");
  scale_range_a: assert property (req_valid && is_wr_one && hit_os &&
    req_wdata > 16'h00ff |=> $stable(out_scale) && rsp_err == ERR_VALUE)
    else $error("out of range scale taken");
  fire_code_a: assert property (wr_en && hit_fire && req_wdata == 16'h000a |=>
    fire_mode == FIRE_M_HALF)
    else $error("half cycle firing not decoded");
  fb_code_a: assert property (wr_en && hit_fb && req_wdata == 16'h0002 |=>
    fb_mode == FB_M_CURRENT)
    else $error("current feedback not decoded");
  bad_func_a: assert property (req_valid && !req_bcast && req_func != FN_READ &&
    req_func != FN_WRITE_ONE && req_func != FN_WRITE_MANY |=>
    rsp_valid && rsp_err == ERR_FUNCTION)
    else $error("unsupported function not refused");
  ilimit_flag_a: assert property (status_read_s |=>
    rsp_data[4] == $past(ilimit_alarm, 3))
    else $error("status bit 4 does not follow current limit alarm");
  thermal_flag_a: assert property (status_read_s |=>
    rsp_data[5] == $past(thermal_alarm, 3))
    else $error("status bit 5 does not follow thermal alarm");
  comm_flag_a: assert property (status_read_s |=>
    rsp_data[6] == $past(comm_alarm, 3))
    else $error("status bit 6 does not follow link alarm");
  dig_in1_flag_a: assert property (status_read_s |=>
    rsp_data[8] == $past(dig_in1, 3))
    else $error("status bit 8 does not follow input one");
  unbalance_flag_a: assert property (status_read_s |=>
    rsp_data[10] == $past(unbalance_alarm, 3))
    else $error("status bit 10 does not follow unbalance alarm");
  phase_loss_flag_a: assert property (status_read_s |=>
    rsp_data[13] == $past(phase_loss_alarm, 3))
    else $error("status bit 13 does not follow phase loss alarm");
  latch_clear_a: assert property (therm_latch_clr && !pin_q[3] |=> !therm_latch_q)
    else $error("latched thermal alarm not cleared");
  latch_set_a: assert property (pin_q[3] && therm_latch_clr |=> therm_latch_q)
    else $error("clear won over a live thermal alarm");
  answer_pulse_a: assert property (req_valid && !req_bcast |=> rsp_valid)
    else $error("request not answered in the next cycle");
  bcast_silent_a: assert property (!(req_valid && !req_bcast) |=> !rsp_valid)
    else $error("answer without an addressed request");
  status_write_a: assert property (req_valid && req_func == FN_WRITE_ONE &&
    req_addr == ADDR_STATUS |=> rsp_err == ERR_ADDRESS && rsp_data == 16'h0000)
    else $error("write to status word not refused");
  qty_zero_a: assert property (req_valid && req_func == FN_READ &&
    req_qty == 16'h0000 |=> rsp_err == ERR_QUANTITY)
    else $error("read of zero words not refused");
  il_local_write_a: assert property (wr_en && hit_cmd |=>
    il_local == $past(req_wdata[4]))
    else $error("current limit source not applied");

endmodule : pcp_regs

// ==== testbench/pcp_host.sv ====
module pcp_host (
  // Clock
  input wire logic mclk,
  // Word requests
  output logic req_valid,
  output logic req_bcast,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_qty,
  output logic [15:0] req_wdata,
  // Answers
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [7:0] rsp_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic got_valid;
  logic [15:0] got_data;
  logic [7:0] got_err;

  initial begin
    req_valid = 1'b0;
    req_bcast = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_qty = 16'h0000;
    req_wdata = 16'h0000;
  end

  // One word request, answer sampled mid-cycle after the taking edge
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q,
                      input logic [15:0] d, input logic bc);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_bcast <= bc;
    req_func <= f;
    req_addr <= a;
    req_qty <= q;
    req_wdata <= d;
    @(posedge mclk);
    req_valid <= 1'b0;
    req_bcast <= 1'b0;
    // Released lines show a changed value, not the old one
    req_addr <= ~a;
    req_wdata <= ~d;
    @(negedge mclk);
    got_valid = rsp_valid;
    got_data = rsp_data;
    got_err = rsp_err;
  endtask : xfer
endmodule : pcp_host

// ==== testbench/tb_power_control_param_registers.sv ====
module tb_power_control_param_registers;
  timeunit 1ns;
  timeprecision 1ps;
  import pcp_pkg::*;
  logic mclk, rstn, therm_latch_clr, req_valid, req_bcast, rsp_valid;
  logic [7:0] req_func, rsp_err, out_scale, min_burst, half_delay;
  logic [15:0] req_addr, req_qty, req_wdata, rsp_data;
  logic [11:0] pins;
  logic sp_local, il_local, out_enable;
  logic [9:0] set_point, current_limit;
  pcp_fire_type fire_mode;
  pcp_fb_type fb_mode;
  int err_count = 0;
  int n_tests = 0;
  int pos [12] = '{0, 1, 4, 5, 6, 7, 8, 9, 10, 12, 13, 14};
  logic [15:0] fires [7] = '{16'h0003, 16'h0004, 16'h000a, 16'h0013, 16'h0014, 16'h0023, 16'h004a};
  logic [15:0] fbs [7] = '{16'h0000, 16'h0001, 16'h0002, 16'h0020, 16'h0040, 16'h0080, 16'h0100};

  pcp_host HOST (.mclk(mclk), .req_valid(req_valid), .req_bcast(req_bcast),
    .req_func(req_func), .req_addr(req_addr), .req_qty(req_qty), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err));

  pcp_regs DUT (.mclk(mclk), .rstn(rstn), .req_valid(req_valid), .req_bcast(req_bcast),
    .req_func(req_func), .req_addr(req_addr), .req_qty(req_qty), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
    .scr_short(pins[0]), .heater_break(pins[1]), .ilimit_alarm(pins[2]),
    .thermal_alarm(pins[3]), .comm_alarm(pins[4]), .fuse_alarm(pins[5]),
    .dig_in1(pins[6]), .dig_in2(pins[7]), .unbalance_alarm(pins[8]), .fan_alarm(pins[9]),
    .phase_loss_alarm(pins[10]), .bakeout_active(pins[11]), .therm_latch_clr(therm_latch_clr),
    .sp_local(sp_local), .il_local(il_local), .out_enable(out_enable), .set_point(set_point),
    .out_scale(out_scale), .current_limit(current_limit), .fire_mode(fire_mode),
    .fb_mode(fb_mode), .min_burst(min_burst), .half_delay(half_delay));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q,
                     input logic [15:0] d, input logic [7:0] e_err, input logic [15:0] e_dat);
    HOST.xfer(f, a, q, d, 1'b0);
    check({15'h0000, HOST.got_valid}, 16'h0001);
    check({8'h00, HOST.got_err}, {8'h00, e_err});
    check(HOST.got_data, e_dat);
  endtask : req

  task automatic rd(input logic [15:0] a, input logic [15:0] e_dat);
    req(FN_READ, a, 16'h0001, 16'h0000, ERR_NONE, e_dat);
  endtask : rd

  task automatic t_reset();
    rd(ADDR_STATUS, 16'h0000);
    rd(ADDR_COMMAND, 16'h0000);
    rd(ADDR_SET_POINT, 16'h0000);
    rd(ADDR_OUT_SCALE, 16'h00ff);
    rd(ADDR_I_CEILING, 16'h03ff);
    rd(ADDR_FIRING, 16'h0003);
    rd(ADDR_FEEDBACK, 16'h0000);
    rd(ADDR_MIN_BURST, 16'h0001);
    rd(ADDR_HALF_DELAY, 16'h0000);
  endtask : t_reset

  task automatic t_status();
    logic [15:0] e;
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk);
      pins <= 12'(1) << i;
      @(posedge mclk);
      // The latch shows one cycle after the live thermal bit
      e = (16'h0001 << pos[i]) | ((i > 3) ? 16'h8000 : 16'h0000);
      rd(ADDR_STATUS, e);
    end
    @(posedge mclk);
    pins <= 12'h000;
    @(posedge mclk);
    rd(ADDR_STATUS, 16'h8000);
    @(posedge mclk);
    therm_latch_clr <= 1'b1;
    @(posedge mclk);
    therm_latch_clr <= 1'b0;
    rd(ADDR_STATUS, 16'h0000);
    // Alarm and clear together: the alarm keeps the latch set
    @(posedge mclk);
    pins <= 12'h008;
    therm_latch_clr <= 1'b1;
    repeat (4) @(posedge mclk);
    therm_latch_clr <= 1'b0;
    pins <= 12'h000;
    rd(ADDR_STATUS, 16'h8020);
    @(posedge mclk);
    therm_latch_clr <= 1'b1;
    @(posedge mclk);
    therm_latch_clr <= 1'b0;
    rd(ADDR_STATUS, 16'h0000);
  endtask : t_status

  task automatic t_command();
    req(FN_WRITE_ONE, ADDR_COMMAND, 16'h0001, 16'hffff, ERR_NONE, 16'hffff);
    check({13'h0000, sp_local, out_enable, il_local}, 16'h0007);
    rd(ADDR_COMMAND, 16'h001c);
    rd(ADDR_STATUS, 16'h0004);
    req(FN_WRITE_ONE, ADDR_COMMAND, 16'h0001, 16'hfff7, ERR_NONE, 16'hfff7);
    check({13'h0000, sp_local, out_enable, il_local}, 16'h0005);
    rd(ADDR_STATUS, 16'h0000);
    req(FN_WRITE_ONE, ADDR_COMMAND, 16'h0001, 16'h0008, ERR_NONE, 16'h0008);
    check({13'h0000, sp_local, out_enable, il_local}, 16'h0002);
  endtask : t_command

  task automatic t_range();
    logic [15:0] ad [5] = '{ADDR_SET_POINT, ADDR_OUT_SCALE, ADDR_I_CEILING, ADDR_MIN_BURST,
                            ADDR_HALF_DELAY};
    logic [15:0] mx [5] = '{16'h03ff, 16'h00ff, 16'h03ff, 16'h00ff, 16'h00ff};
    for (int i = 0; i < 5; i++) begin
      req(FN_WRITE_ONE, ad[i], 16'h0001, mx[i], ERR_NONE, mx[i]);
      req(FN_WRITE_ONE, ad[i], 16'h0001, mx[i] + 16'h0001, ERR_VALUE, 16'h0000);
      rd(ad[i], mx[i]);
    end
    check({6'h00, set_point}, 16'h03ff);
    check({8'h00, out_scale}, 16'h00ff);
    check({current_limit, 6'h00}, 16'hffc0);
    check({min_burst, half_delay}, 16'hffff);
    req(FN_WRITE_MANY, ADDR_SET_POINT, 16'h0002, 16'h0155, ERR_NONE, 16'h0155);
    req(FN_WRITE_MANY, ADDR_OUT_SCALE, 16'h0002, 16'h00aa, ERR_NONE, 16'h00aa);
    check({6'h00, set_point}, 16'h0155);
    check({8'h00, out_scale}, 16'h00aa);
  endtask : t_range

  task automatic t_codes();
    for (int i = 0; i < 7; i++) begin
      req(FN_WRITE_ONE, ADDR_FIRING, 16'h0001, fires[i], ERR_NONE, fires[i]);
      check({13'h0000, fire_mode}, 16'(i));
      rd(ADDR_FIRING, fires[i]);
      req(FN_WRITE_ONE, ADDR_FEEDBACK, 16'h0001, fbs[i], ERR_NONE, fbs[i]);
      check({13'h0000, fb_mode}, 16'(i));
      rd(ADDR_FEEDBACK, fbs[i]);
    end
    req(FN_WRITE_ONE, ADDR_FIRING, 16'h0001, 16'h0005, ERR_VALUE, 16'h0000);
    req(FN_WRITE_ONE, ADDR_FEEDBACK, 16'h0001, 16'h0003, ERR_VALUE, 16'h0000);
    check({10'h000, fire_mode, fb_mode}, 16'h0036);
  endtask : t_codes

  task automatic t_errors();
    logic [7:0] fn [9] = '{8'h04, 8'h04, FN_READ, FN_READ, FN_WRITE_MANY, FN_READ, FN_WRITE_ONE,
                           FN_READ, FN_WRITE_MANY};
    logic [15:0] ad [9] = '{16'h000f, 16'h0016, 16'h0016, 16'h000f, 16'h000f, 16'h0016,
                            16'h000d, 16'h000c, 16'h000f};
    logic [15:0] qt [9] = '{16'h0001, 16'h0000, 16'h0000, 16'h007a, 16'h001a, 16'h0001,
                            16'h0001, 16'h0001, 16'h0000};
    logic [7:0] er [9] = '{ERR_FUNCTION, ERR_FUNCTION, ERR_QUANTITY, ERR_QUANTITY, ERR_QUANTITY,
                           ERR_ADDRESS, ERR_ADDRESS, ERR_ADDRESS, ERR_QUANTITY};
    for (int i = 0; i < 9; i++) begin
      req(fn[i], ad[i], qt[i], 16'h0000, er[i], 16'h0000);
    end
    req(FN_READ, ADDR_SET_POINT, 16'h0079, 16'h0000, ERR_NONE, 16'h0155);
    req(FN_WRITE_MANY, ADDR_MIN_BURST, 16'h0019, 16'h0007, ERR_NONE, 16'h0007);
    HOST.xfer(FN_WRITE_ONE, ADDR_HALF_DELAY, 16'h0001, 16'h0042, 1'b1);
    check({15'h0000, HOST.got_valid}, 16'h0000);
    check({min_burst, half_delay}, 16'h0742);
  endtask : t_errors

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    rstn = 1'b0;
    pins = 12'h000;
    therm_latch_clr = 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_status();
    t_command();
    t_range();
    t_codes();
    t_errors();
    print_verdict();
  end

  // Guard against a hung run
  initial begin
    #2ms;
    err_count++;
    print_verdict();
  end
endmodule : tb_power_control_param_registers
